// file: core/ingress_regs_pkg.sv
// ingress_regs_pkg: offsets, field positions, reset values and state codes
// shared by the per-port ingress control register bank and its helpers.
// assumes one port instance per bank; the port nibble is decoded upstream.
package ingress_regs_pkg;

    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;
    localparam int PRIO_W = 3;
    localparam int NUM_SRC = 5;
    localparam int INDEX_W = 4;
    localparam int BE_W = 16;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_BE_MSB = 12'h610;
    localparam logic [11:0] IDX_BE_LSB = 12'h611;
    localparam logic [11:0] IDX_RULE_CTRL = 12'h612;
    localparam logic [11:0] IDX_MIRROR = 12'h800;
    localparam logic [11:0] IDX_PRIO_SEL = 12'h801;
    localparam logic [11:0] IDX_DEF_PRIO = 12'h802;
    localparam logic [11:0] IDX_IRQ_STAT = 12'h8f0;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h8f1;

    // rule access control fields
    localparam int RC_WR_DONE_BIT = 6;
    localparam int RC_RD_DONE_BIT = 5;
    localparam int RC_DIR_BIT = 4;

    // mirroring control fields
    localparam int MIR_RX_BIT = 6;
    localparam int MIR_TX_BIT = 5;
    localparam int MIR_SNIFF_BIT = 1;
    localparam logic [7:0] MIR_WMASK = 8'h62;

    // priority select fields; bits 4:0 are the source enables
    localparam int PS_HIGHEST_BIT = 7;
    localparam int PS_OR_BIT = 6;
    localparam logic [7:0] PS_WMASK = 8'hdf;

    // interrupt status fields
    localparam int IRQ_WR_BIT = 0;
    localparam int IRQ_RD_BIT = 1;
    localparam logic [7:0] IRQ_WMASK = 8'h03;

    // values after reset
    localparam logic RST_DONE = 1'b1;
    localparam logic RST_DIR = 1'b0;
    localparam logic [INDEX_W-1:0] RST_INDEX = 4'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [PRIO_W-1:0] RST_DEF_PRIO = 3'h0;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_BUSY = 2'b10
    } seq_state_e;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [11:0] idx);
        return {idx, 2'b00};
    endfunction : reg_addr

endpackage : ingress_regs_pkg

// file: core/rule_access_seq.sv
// rule_access_seq: runs one indirect rule-table read or write at a time.
// assumes the rule table answers tbl_ack on clk_sys for each request.
`timescale 1ns/1ps
`default_nettype none
module rule_access_seq (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic launch,
    input wire logic dir_write,
    input wire logic [ingress_regs_pkg::INDEX_W-1:0] index,
    input wire logic [ingress_regs_pkg::BE_W-1:0] byte_en,
    input wire logic tbl_ack,
    output logic tbl_req,
    output logic tbl_write,
    output logic [ingress_regs_pkg::INDEX_W-1:0] tbl_index,
    output logic [ingress_regs_pkg::BE_W-1:0] tbl_byte_en,
    output logic wr_done,
    output logic rd_done,
    output logic wr_event,
    output logic rd_event
);
    import ingress_regs_pkg::*;

    seq_state_e state_q;
    seq_state_e state_d;
    wire logic start = launch && (state_q == SEQ_IDLE);
    wire logic finish = tbl_ack && (state_q == SEQ_BUSY);

    always_comb begin
        case (state_q)
            SEQ_IDLE: state_d = start ? SEQ_BUSY : SEQ_IDLE;
            SEQ_BUSY: state_d = tbl_ack ? SEQ_IDLE : SEQ_BUSY;
            default: state_d = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= SEQ_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // request is held until the table acknowledges; fields latched at start
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tbl_req <= 1'b0;
            tbl_write <= RST_DIR;
            tbl_index <= RST_INDEX;
            tbl_byte_en <= {RST_BYTE, RST_BYTE};
        end else if (start) begin
            tbl_req <= 1'b1; // R5
            tbl_write <= dir_write;
            tbl_index <= index;
            tbl_byte_en <= byte_en; // R5
        end else if (finish) begin
            tbl_req <= 1'b0;
        end
    end

    // each completion flag drops at a launch in its own direction and rises when the table answers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wr_done <= RST_DONE;
            rd_done <= RST_DONE;
            wr_event <= 1'b0;
            rd_event <= 1'b0;
        end else begin
            wr_event <= finish && tbl_write;
            rd_event <= finish && !tbl_write;
            if (start && dir_write) begin
                wr_done <= 1'b0; // R1
            end else if (finish && tbl_write) begin
                wr_done <= 1'b1; // R1
            end
            if (start && !dir_write) begin
                rd_done <= 1'b0; // R2
            end else if (finish && !tbl_write) begin
                rd_done <= 1'b1; // R2
            end
        end
    end

endmodule : rule_access_seq
`default_nettype wire

// file: core/prio_resolver.sv
// prio_resolver: combines the enabled classification sources of one packet.
// assumes source priorities and hit flags are stable while cls_valid is high.
`timescale 1ns/1ps
`default_nettype none
module prio_resolver (
    input wire logic [7:0] prio_sel,
    input wire logic [ingress_regs_pkg::PRIO_W-1:0] def_prio,
    input wire logic [ingress_regs_pkg::NUM_SRC*3-1:0] src_prio,
    input wire logic [ingress_regs_pkg::NUM_SRC-1:0] src_hit,
    output logic [ingress_regs_pkg::PRIO_W-1:0] prio
);
    import ingress_regs_pkg::*;

    logic [PRIO_W-1:0] masked [NUM_SRC];
    logic [NUM_SRC-1:0] live;

    // bit i of prio_sel enables source i: acl, dscp, 802.1p, vlan, mac
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            assign live[g] = prio_sel[g] && src_hit[g]; // R13 R14 R15 R16 R17
            assign masked[g] = live[g] ? src_prio[g*3 +: 3] : 3'h0;
        end
    endgenerate

    logic [PRIO_W-1:0] hi;
    logic [PRIO_W-1:0] ored;
    logic [PRIO_W-1:0] first;

    // first hit in index order wins when no combining mode is chosen
    always_comb begin
        hi = 3'h0;
        ored = 3'h0;
        first = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (masked[i] > hi) begin
                hi = masked[i];
            end
            ored = ored | masked[i];
            if (live[i]) begin
                first = masked[i];
            end
        end
    end

    always_comb begin
        if (live == '0) begin
            prio = def_prio; // R18
        end else if (prio_sel[PS_HIGHEST_BIT]) begin
            prio = hi; // R11
        end else if (prio_sel[PS_OR_BIT]) begin
            prio = ored; // R12
        end else begin
            prio = first;
        end
    end

endmodule : prio_resolver
`default_nettype wire

// file: core/port_ingress_ctrl_regs.sv
// port_ingress_ctrl_regs: per-port rule access, mirroring and priority
// selection registers behind an avalon-mm slave with waitrequest.
// assumes a single clk_sys domain; packet and table strobes share it.
//
// What this block does
// R1 - write-complete bit 6 reads 0 during a table write, 1 after; resets 1
// R2 - read-complete bit 5 reads 0 during a table read, 1 after; resets 1
// R3 - software polls read-complete until 1 before fetching read results
// R4 - bit 4 picks direction (1 write), bits 3:0 pick entry; reset 0
// R5 - writing byte-enable low launches access; only enabled bytes take part
// R6 - receive sniff bit 6 marks received packets monitored, copies to sniffer
// R7 - transmit sniff bit 5 marks sent packets monitored, copies to sniffer
// R8 - bit 1 makes this port the sniffer port; clear means normal
// R9 - software also sets global mirroring control for mirroring to work
// R10 - software sets at most one priority control bit at a time
// R11 - bit 7 uses the highest priority among enabled sources
// R12 - bit 6 ors all available classified priorities together
// R13 - bit 4 enables mac address priority classification
// R14 - bit 3 enables vlan priority classification
// R15 - bit 2 enables 802.1p user priority classification
// R16 - bit 1 enables diffserv priority classification
// R17 - bit 0 enables rule action priority classification
// R18 - nothing enabled or nothing classified gives the default priority 0-7
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module port_ingress_ctrl_regs (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ingress_regs_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [ingress_regs_pkg::DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [ingress_regs_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    output logic irq,
    output logic tbl_req,
    output logic tbl_write,
    output logic [ingress_regs_pkg::INDEX_W-1:0] tbl_index,
    output logic [ingress_regs_pkg::BE_W-1:0] tbl_byte_en,
    input wire logic tbl_ack,
    input wire logic rx_pkt_start,
    input wire logic tx_pkt_start,
    output logic rx_monitored,
    output logic tx_monitored,
    output logic sniffer_port,
    input wire logic cls_valid,
    input wire logic [ingress_regs_pkg::NUM_SRC*3-1:0] src_prio,
    input wire logic [ingress_regs_pkg::NUM_SRC-1:0] src_hit,
    output logic [ingress_regs_pkg::PRIO_W-1:0] pkt_prio,
    output logic pkt_prio_valid
);
    import ingress_regs_pkg::*;

    // ---------------- bus handshake ----------------
    // one wait state: waitrequest drops for the cycle after a request arrives
    logic wait_q;
    wire logic req = read || write;
    wire logic take = req && !wait_q;
    wire logic wr_take = write && !wait_q && byteenable[0];
    wire logic rd_take = read && !wait_q;
    wire logic [7:0] wbyte = writedata[7:0];

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !(req && wait_q);
        end
    end

    assign waitrequest = wait_q;

    // ---------------- address decode ----------------
    wire logic hit_be_msb = address == reg_addr(IDX_BE_MSB);
    wire logic hit_be_lsb = address == reg_addr(IDX_BE_LSB);
    wire logic hit_rule_ctrl = address == reg_addr(IDX_RULE_CTRL);
    wire logic hit_mirror = address == reg_addr(IDX_MIRROR);
    wire logic hit_prio_sel = address == reg_addr(IDX_PRIO_SEL);
    wire logic hit_def_prio = address == reg_addr(IDX_DEF_PRIO);
    wire logic hit_irq_stat = address == reg_addr(IDX_IRQ_STAT);
    wire logic hit_irq_mask = address == reg_addr(IDX_IRQ_MASK);

    // ---------------- software registers ----------------
    logic dir_q;
    logic [INDEX_W-1:0] index_q;
    logic [7:0] be_msb_q;
    logic [7:0] be_lsb_q;
    logic [7:0] mirror_q;
    logic [7:0] prio_sel_q;
    logic [PRIO_W-1:0] def_prio_q;
    logic [7:0] irq_mask_q;

    // write strobes, one per register except the read-cleared interrupt status
    wire logic wr_rule_ctrl = wr_take && hit_rule_ctrl;
    wire logic wr_be_msb = wr_take && hit_be_msb;
    wire logic wr_be_lsb = wr_take && hit_be_lsb;
    wire logic wr_mirror = wr_take && hit_mirror;
    wire logic wr_prio_sel = wr_take && hit_prio_sel;
    wire logic wr_def_prio = wr_take && hit_def_prio;
    wire logic wr_irq_mask = wr_take && hit_irq_mask;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dir_q <= RST_DIR;
            index_q <= RST_INDEX;
        end else if (wr_rule_ctrl) begin
            dir_q <= wbyte[RC_DIR_BIT]; // R4
            index_q <= wbyte[INDEX_W-1:0]; // R4
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            be_msb_q <= RST_BYTE;
        end else if (wr_be_msb) begin
            be_msb_q <= wbyte;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            be_lsb_q <= RST_BYTE;
        end else if (wr_be_lsb) begin
            be_lsb_q <= wbyte;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mirror_q <= RST_BYTE;
        end else if (wr_mirror) begin
            mirror_q <= wbyte & MIR_WMASK;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prio_sel_q <= RST_BYTE;
        end else if (wr_prio_sel) begin
            prio_sel_q <= wbyte & PS_WMASK;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            def_prio_q <= RST_DEF_PRIO;
        end else if (wr_def_prio) begin
            def_prio_q <= wbyte[PRIO_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_mask_q <= RST_BYTE;
        end else if (wr_irq_mask) begin
            irq_mask_q <= wbyte & IRQ_WMASK;
        end
    end

    // ---------------- rule table access ----------------
    // a write of the low byte-enable register launches with the new value
    wire logic launch = wr_be_lsb; // R5
    wire logic [BE_W-1:0] launch_be = {be_msb_q, wbyte};
    logic wr_done;
    logic rd_done;
    logic wr_event;
    logic rd_event;

    rule_access_seq rule_access_seq_i (
        .clk_sys(clk_sys),
        .reset(reset),
        .launch(launch),
        .dir_write(dir_q),
        .index(index_q),
        .byte_en(launch_be),
        .tbl_ack(tbl_ack),
        .tbl_req(tbl_req),
        .tbl_write(tbl_write),
        .tbl_index(tbl_index),
        .tbl_byte_en(tbl_byte_en),
        .wr_done(wr_done),
        .rd_done(rd_done),
        .wr_event(wr_event),
        .rd_event(rd_event)
    );

    // ---------------- interrupts ----------------
    // sticky events; a read clears only the bits it returned, so an event
    // that lands after the data was loaded is kept, and set wins
    logic [7:0] irq_stat_q;
    wire logic stat_clr = rd_take && hit_irq_stat;
    wire logic [7:0] events = {6'h00, rd_event, wr_event};
    wire logic [7:0] stat_seen = stat_clr ? readdata[7:0] : 8'h00;
    wire logic [7:0] stat_next = (irq_stat_q & ~stat_seen) | events;
    wire logic irq_next = |(stat_next & irq_mask_q);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_stat_q <= RST_BYTE;
        end else begin
            irq_stat_q <= stat_next;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_next;
        end
    end

    // ---------------- read data ----------------
    wire logic [7:0] rule_ctrl_rd = {1'b0, wr_done, rd_done, dir_q, index_q};
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (hit_be_msb) begin
            rd_byte = be_msb_q;
        end
        if (hit_be_lsb) begin
            rd_byte = be_lsb_q;
        end
        if (hit_rule_ctrl) begin
            rd_byte = rule_ctrl_rd; // R1 R2 R4
        end
        if (hit_mirror) begin
            rd_byte = mirror_q;
        end
        if (hit_prio_sel) begin
            rd_byte = prio_sel_q;
        end
        if (hit_def_prio) begin
            rd_byte = {5'h00, def_prio_q};
        end
        if (hit_irq_stat) begin
            rd_byte = irq_stat_q;
        end
        if (hit_irq_mask) begin
            rd_byte = irq_mask_q;
        end
    end

    // data is loaded while waitrequest is high so it stands at the taken edge
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            readdata <= '0;
        end else if (read && wait_q) begin
            readdata <= {24'h000000, rd_byte};
        end else if (take) begin
            readdata <= '0;
        end
    end

    // ---------------- mirroring ----------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rx_monitored <= 1'b0;
            tx_monitored <= 1'b0;
        end else begin
            rx_monitored <= rx_pkt_start && mirror_q[MIR_RX_BIT]; // R6
            tx_monitored <= tx_pkt_start && mirror_q[MIR_TX_BIT]; // R7
        end
    end

    // role flag follows the register one cycle late
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sniffer_port <= 1'b0;
        end else begin
            sniffer_port <= mirror_q[MIR_SNIFF_BIT]; // R8
        end
    end

    // ---------------- priority classification ----------------
    logic [PRIO_W-1:0] prio_comb;

    prio_resolver prio_resolver_i (
        .prio_sel(prio_sel_q),
        .def_prio(def_prio_q),
        .src_prio(src_prio),
        .src_hit(src_hit),
        .prio(prio_comb)
    );

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pkt_prio_valid <= 1'b0;
        end else begin
            pkt_prio_valid <= cls_valid;
        end
    end

    // the result holds between packets
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pkt_prio <= RST_DEF_PRIO;
        end else if (cls_valid) begin
            pkt_prio <= prio_comb; // R11 R12 R18
        end
    end

endmodule : port_ingress_ctrl_regs
`default_nettype wire

// file: tb/port_ingress_ctrl_regs_properties.sv
// checker for the port ingress control register bank
// assumes one clk_sys domain and the bank's own port names
`timescale 1ns/1ps
`default_nettype none
module port_ingress_ctrl_regs_properties (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ingress_regs_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [ingress_regs_pkg::DATA_W-1:0] readdata,
    input wire logic waitrequest,
    input wire logic tbl_req,
    input wire logic tbl_write,
    input wire logic [ingress_regs_pkg::INDEX_W-1:0] tbl_index,
    input wire logic [ingress_regs_pkg::BE_W-1:0] tbl_byte_en,
    input wire logic tbl_ack,
    input wire logic rx_pkt_start,
    input wire logic tx_pkt_start,
    input wire logic rx_monitored,
    input wire logic tx_monitored,
    input wire logic cls_valid,
    input wire logic [ingress_regs_pkg::PRIO_W-1:0] pkt_prio,
    input wire logic pkt_prio_valid
);
    import ingress_regs_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_wait_answer: assert property ((read || write) && waitrequest |=>
        !waitrequest) else $error("bus answer late");
    a_wait_one: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    a_idle_readdata: assert property (waitrequest |-> readdata == 32'h0)
        else $error("readdata not cleared");
    a_launch_req: assert property (write && !waitrequest && byteenable[0] &&
        address == {IDX_BE_LSB, 2'b00} && !tbl_req |=> tbl_req)
        else $error("launch did not request");
    a_req_hold: assert property (tbl_req && !tbl_ack |=> tbl_req &&
        $stable(tbl_write) && $stable(tbl_index) && $stable(tbl_byte_en))
        else $error("table request changed");
    a_req_drop: assert property (tbl_req && tbl_ack |=> !tbl_req)
        else $error("table request held after ack");
    a_rx_mark: assert property (rx_monitored |-> $past(rx_pkt_start))
        else $error("rx mark without packet");
    a_tx_mark: assert property (tx_monitored |-> $past(tx_pkt_start))
        else $error("tx mark without packet");
    a_prio_valid: assert property (pkt_prio_valid == $past(cls_valid))
        else $error("priority valid misplaced");
    a_prio_stable: assert property (!$past(cls_valid) |-> $stable(pkt_prio))
        else $error("priority changed without request");
endmodule : port_ingress_ctrl_regs_properties
bind port_ingress_ctrl_regs port_ingress_ctrl_regs_properties
    port_ingress_ctrl_regs_properties_i (.clk_sys, .reset, .address, .read,
    .write, .byteenable, .readdata, .waitrequest, .tbl_req, .tbl_write,
    .tbl_index, .tbl_byte_en, .tbl_ack, .rx_pkt_start, .tx_pkt_start,
    .rx_monitored, .tx_monitored, .cls_valid, .pkt_prio, .pkt_prio_valid);
`default_nettype wire

// file: tb/port_ingress_ctrl_regs_tb.sv
// testbench for the port ingress control register bank
// assumes the bank answers every avalon access and drives the table side
`timescale 1ns/1ps
`default_nettype none
module port_ingress_ctrl_regs_tb;
    import ingress_regs_pkg::*;
    logic clk_sys, reset, read, write, tbl_ack, rx_pkt_start, tx_pkt_start;
    logic cls_valid, waitrequest, irq, tbl_req, tbl_write, rx_monitored;
    logic tx_monitored, sniffer_port, pkt_prio_valid;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata, readdata, rd;
    logic [3:0] byteenable;
    logic [INDEX_W-1:0] tbl_index;
    logic [BE_W-1:0] tbl_byte_en;
    logic [NUM_SRC*3-1:0] src_prio;
    logic [NUM_SRC-1:0] src_hit;
    logic [PRIO_W-1:0] pkt_prio;
    logic [7:0] mv [5] = '{8'hff, 8'h40, 8'h20, 8'h02, 8'h00};
    int fails, tests_run, n;

    port_ingress_ctrl_regs port_ingress_ctrl_regs_i (.clk_sys, .reset,
        .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .irq, .tbl_req, .tbl_write, .tbl_index, .tbl_byte_en,
        .tbl_ack, .rx_pkt_start, .tx_pkt_start, .rx_monitored, .tx_monitored,
        .sniffer_port, .cls_valid, .src_prio, .src_hit, .pkt_prio,
        .pkt_prio_valid);

    task automatic conclude;
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_sig(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: port %h expected %h", $time, got, exp);
        end
    endtask : chk_sig

    task automatic wait_ack;
        int k;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        if (k >= 50) begin
            fails++;
            $display("mismatch at %0t: no bus answer", $time);
        end
    endtask : wait_ack

    task automatic bus_wr(input logic [11:0] idx, input logic [7:0] d,
                          input logic [3:0] be);
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        byteenable <= be;
        write <= 1'b1;
        wait_ack();
        write <= 1'b0;
        @(posedge clk_sys);
    endtask : bus_wr

    task automatic bus_rd(input logic [11:0] idx, output logic [31:0] q);
        address <= {idx, 2'b00};
        read <= 1'b1;
        wait_ack();
        q = readdata;
        read <= 1'b0;
        @(posedge clk_sys);
    endtask : bus_rd

    task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp);
        bus_rd(idx, rd);
        chk_reg(rd, {24'h0, exp});
    endtask : rd_chk

    task automatic ack;
        tbl_ack <= 1'b1;
        @(posedge clk_sys);
        tbl_ack <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : ack

    // both strobes at once; marks follow the mirror bits
    task automatic pkt(input logic [7:0] m);
        rx_pkt_start <= 1'b1;
        tx_pkt_start <= 1'b1;
        @(posedge clk_sys);
        rx_pkt_start <= 1'b0;
        tx_pkt_start <= 1'b0;
        @(posedge clk_sys);
        chk_sig({rx_monitored, tx_monitored, sniffer_port}, {m[6], m[5], m[1]});
    endtask : pkt

    task automatic cls(input logic [7:0] sel, input logic [4:0] hit,
                       input logic [2:0] exp);
        bus_wr(IDX_PRIO_SEL, sel, 4'h1);
        src_hit <= hit;
        cls_valid <= 1'b1;
        @(posedge clk_sys);
        cls_valid <= 1'b0;
        @(posedge clk_sys);
        chk_sig({pkt_prio_valid, pkt_prio}, {1'b1, exp});
    endtask : cls

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude();
    end

    initial begin
        {read, write, tbl_ack, rx_pkt_start, tx_pkt_start, cls_valid} = '0;
        address = '0;
        writedata = '0;
        byteenable = 4'h0;
        // per source: mac 2, vlan 6, 802.1p 1, diffserv 5, rule 3
        src_prio = {3'h2, 3'h6, 3'h1, 3'h5, 3'h3};
        src_hit = 5'h1f;
        reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk_sig({irq, sniffer_port, tbl_req}, 32'h0);
        rd_chk(IDX_RULE_CTRL, 8'h60);
        rd_chk(IDX_MIRROR, 8'h00);
        rd_chk(IDX_PRIO_SEL, 8'h00);
        rd_chk(IDX_DEF_PRIO, 8'h00);
        rd_chk(IDX_IRQ_MASK, 8'h00);
        rd_chk(12'h123, 8'h00);
        bus_wr(IDX_MIRROR, 8'hff, 4'h0);
        rd_chk(IDX_MIRROR, 8'h00);
        bus_wr(IDX_RULE_CTRL, 8'hff, 4'h1);
        rd_chk(IDX_RULE_CTRL, 8'h7f);
        bus_wr(IDX_RULE_CTRL, 8'h1a, 4'h1);
        bus_wr(IDX_BE_MSB, 8'h81, 4'h1);
        rd_chk(IDX_BE_MSB, 8'h81);
        bus_wr(IDX_IRQ_MASK, 8'hff, 4'h1);
        rd_chk(IDX_IRQ_MASK, 8'h03);
        bus_wr(IDX_BE_LSB, 8'h42, 4'h1);
        chk_sig({tbl_req, tbl_write, tbl_index, tbl_byte_en}, 32'h3a8142);
        rd_chk(IDX_RULE_CTRL, 8'h3a);
        // launch while busy must not restart the access
        bus_wr(IDX_BE_LSB, 8'h11, 4'h1);
        chk_sig({tbl_req, tbl_byte_en}, 32'h18142);
        ack();
        chk_sig(irq, 32'h1);
        rd_chk(IDX_RULE_CTRL, 8'h7a);
        rd_chk(IDX_IRQ_STAT, 8'h01);
        repeat (2) @(posedge clk_sys);
        chk_sig({irq, tbl_req}, 32'h0);
        rd_chk(IDX_IRQ_STAT, 8'h00);
        bus_wr(IDX_IRQ_MASK, 8'h01, 4'h1);
        bus_wr(IDX_RULE_CTRL, 8'h05, 4'h1);
        bus_wr(IDX_BE_LSB, 8'h33, 4'h1);
        chk_sig({tbl_req, tbl_write, tbl_index, tbl_byte_en}, 32'h258133);
        rd_chk(IDX_RULE_CTRL, 8'h45);
        ack();
        n = 0;
        do begin
            bus_rd(IDX_RULE_CTRL, rd);
            n++;
        end while (rd[5] !== 1'b1 && n < 20);
        chk_reg(rd, 32'h65);
        chk_sig(irq, 32'h0);
        rd_chk(IDX_IRQ_STAT, 8'h02);
        for (int i = 0; i < 5; i++) begin
            bus_wr(IDX_MIRROR, mv[i], 4'h1);
            rd_chk(IDX_MIRROR, mv[i] & 8'h62);
            pkt(mv[i]);
        end
        bus_wr(IDX_DEF_PRIO, 8'hfc, 4'h1);
        rd_chk(IDX_DEF_PRIO, 8'h04);
        bus_wr(IDX_PRIO_SEL, 8'hff, 4'h1);
        rd_chk(IDX_PRIO_SEL, 8'hdf);
        cls(8'h01, 5'h1f, 3'h3);
        cls(8'h02, 5'h1f, 3'h5);
        cls(8'h04, 5'h1f, 3'h1);
        cls(8'h08, 5'h1f, 3'h6);
        cls(8'h10, 5'h1f, 3'h2);
        cls(8'h06, 5'h1d, 3'h1);
        cls(8'h00, 5'h1f, 3'h4);
        cls(8'h01, 5'h1e, 3'h4);
        cls(8'h9c, 5'h1f, 3'h6);
        cls(8'h52, 5'h1f, 3'h7);
        cls(8'hdc, 5'h1f, 3'h6);
        conclude();
    end
endmodule : port_ingress_ctrl_regs_tb
`default_nettype wire
